// *** meter_config_registers.sv ***
// configuration registers of the metering front end
// assumes the serial engine presents one-cycle strobes on ref_clk
`timescale 1ns/1ps
module meter_config_registers import meter_cfg_pkg::*; #(
   parameter int BASE_CYCLES = PULSE_BASE_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // register port from the serial engine
   input  wire logic [5:0]  reg_addr,
   input  wire logic [23:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [23:0]      reg_rdata,
   // pulse requests from the rate logic
   input  wire logic [3:0]  epg_trigger,
   // sign and event sources for the pins
   input  wire logic        active_sign1,
   input  wire logic        active_sign2,
   input  wire logic        active_sign_sum,
   input  wire logic        reactive_sign1,
   input  wire logic        reactive_sign2,
   input  wire logic        reactive_sign_sum,
   input  wire logic        voltage_zero_cross,
   input  wire logic        current_zero_cross,
   input  wire logic        interrupt_level,
   // averaged active power results
   input  wire logic        avg_power_valid,
   input  wire logic [23:0] p1_avg_raw,
   input  wire logic [23:0] p2_avg_raw,
   output logic [23:0]      p1_avg,
   output logic [23:0]      p2_avg,
   // line frequency measurement done
   input  wire logic        line_freq_done,
   output logic             epsilon_update,
   // digital output pins
   output logic [3:0]       pin_out,
   output logic [3:0]       pin_oe_n,
   // configuration to the calculation engine
   output logic [3:0]       pulse_gen_enable,
   output logic             apparent_power_method,
   output logic             zero_cross_lowpass,
   output logic             averaging_source,
   output logic             critical_checksum_disable,
   output logic             checksum_uses_cycle_count,
   output logic             auto_line_freq,
   output logic [1:0]       current1_filter_sel,
   output logic [1:0]       current2_filter_sel,
   output logic [1:0]       voltage1_filter_sel,
   output logic [1:0]       voltage2_filter_sel,
   output logic             iir_bypass,
   output logic [1:0]       coarse_phase1,
   output logic [1:0]       coarse_phase2,
   output logic [8:0]       fine_phase1,
   output logic [8:0]       fine_phase2,
   output logic             rx_pullup_disable,
   output logic             rx_checksum_disable,
   output logic [15:0]      baud_divisor,
   output logic [3:0]       pulse_freq_range
);
   // all state of this module
   typedef struct packed {
      logic [23:0] calc_filter_config; // calc options and filters
      logic [23:0] output_pin_config;  // pin routing and enables
      logic [23:0] phase_compensation; // coarse and fine phase
      logic [23:0] serial_control;     // receive options, divisor
      logic [23:0] pulse_width_range;  // pulse width and range
      logic [23:0] rdata;              // read answer
      logic [23:0] p1;                 // stored active power 1
      logic [23:0] p2;                 // stored active power 2
      logic        eps;                // gain update strobe
   } st_t;

   st_t s, next_s;

   logic [3:0]  epg_pulse;  // generator outputs
   logic [15:0] pin_src;    // pin source vector by code
   logic        pos_only;   // positive-only energy
   logic [15:0] width_val;  // pulse width value

   assign pos_only  = s.calc_filter_config[POS_BIT];
   assign width_val = s.pulse_width_range[WIDTH_LSB +: 16];

   // pin sources indexed by selector code
   always_comb begin
      pin_src     = 16'h0000;
      pin_src[3:0] = epg_pulse;
      pin_src[4]  = active_sign1;
      pin_src[5]  = active_sign2;
      pin_src[6]  = active_sign_sum;
      pin_src[7]  = reactive_sign1;
      pin_src[8]  = reactive_sign2;
      pin_src[9]  = reactive_sign_sum;
      pin_src[11] = voltage_zero_cross;
      pin_src[12] = current_zero_cross;
      pin_src[15] = interrupt_level;
   end

   // register writes, reads and result storage
   always_comb begin
      next_s = s;
      next_s.eps = 1'b0;
      // writes keep only published bits
      if (reg_wr) begin
         unique case (reg_addr)
            CALC_FILTER_ADDR: begin
               next_s.calc_filter_config =
                  (reg_wdata & CALC_FILTER_MSK) | CALC_FILTER_ONE;
            end
            OUT_PIN_ADDR: begin
               next_s.output_pin_config = reg_wdata & OUT_PIN_MSK;
            end
            PHASE_ADDR: begin
               next_s.phase_compensation = reg_wdata & PHASE_MSK;
            end
            SERIAL_ADDR: begin
               // divisor value is the host's to compute
               next_s.serial_control = reg_wdata & SERIAL_MSK;
            end
            PULSE_ADDR: begin
               next_s.pulse_width_range = reg_wdata & PULSE_MSK;
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
      // reads answer one cycle later
      if (reg_rd) begin
         unique case (reg_addr)
            CALC_FILTER_ADDR: next_s.rdata = s.calc_filter_config;
            OUT_PIN_ADDR:     next_s.rdata = s.output_pin_config;
            PHASE_ADDR:       next_s.rdata = s.phase_compensation;
            SERIAL_ADDR:      next_s.rdata = s.serial_control;
            PULSE_ADDR:       next_s.rdata = s.pulse_width_range;
            default:          next_s.rdata = 24'h00_0000;
         endcase
      end
      // negative averages stored as zero when asked
      if (avg_power_valid) begin
         if (pos_only && p1_avg_raw[23]) begin
            next_s.p1 = 24'h00_0000;
         end else begin
            next_s.p1 = p1_avg_raw;
         end
         if (pos_only && p2_avg_raw[23]) begin
            next_s.p2 = 24'h00_0000;
         end else begin
            next_s.p2 = p2_avg_raw;
         end
      end
      // one strobe per completed measurement while auto line frequency is on
      if (line_freq_done && s.calc_filter_config[ALF_BIT]) begin
         next_s.eps = 1'b1;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s.calc_filter_config <= CALC_FILTER_RST;
         s.output_pin_config  <= OUT_PIN_RST;
         s.phase_compensation <= PHASE_RST;
         s.serial_control     <= SERIAL_RST;
         s.pulse_width_range  <= PULSE_RST;
         s.rdata              <= 24'h00_0000;
         s.p1                 <= 24'h00_0000;
         s.p2                 <= 24'h00_0000;
         s.eps                <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // four pulse generators and four pins
   generate
      for (genvar i = 0; i < 4; i++) begin : g_ch
         pulse_stretch #(
            .BASE_CYCLES (BASE_CYCLES)
         ) u_pulse (
            .ref_clk (ref_clk),
            .rst     (rst),
            .enable  (s.output_pin_config[EN_LSB + i]),
            .trigger (epg_trigger[i]),
            .width   (width_val),
            .pulse   (epg_pulse[i])
         );
         pin_driver u_pin (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .source_sel (s.output_pin_config[SEL_LSB + 4*i +: 4]),
            .open_drain (s.output_pin_config[OD_LSB + i]),
            .sources    (pin_src),
            .pin_out    (pin_out[i]),
            .pin_oe_n   (pin_oe_n[i])
         );
      end
   endgenerate

   // register port answer
   assign reg_rdata = s.rdata;

   // stored power results
   assign p1_avg = s.p1;
   assign p2_avg = s.p2;
   assign epsilon_update = s.eps;

   // pulse generator enables
   assign pulse_gen_enable = s.output_pin_config[EN_LSB +: 4];

   // calculation options
   assign apparent_power_method =
      s.calc_filter_config[APM_BIT];
   assign zero_cross_lowpass =
      s.calc_filter_config[ZXLPF_BIT];
   assign averaging_source =
      s.calc_filter_config[AVG_BIT];
   assign critical_checksum_disable =
      s.calc_filter_config[CSUM_BIT];
   // the count register that the checksum covers follows the source
   assign checksum_uses_cycle_count =
      s.calc_filter_config[AVG_BIT];
   assign auto_line_freq =
      s.calc_filter_config[ALF_BIT];

   // filter selectors; reserved voltage code is passed as written
   assign current1_filter_sel =
      s.calc_filter_config[I1F_LSB +: 2];
   assign current2_filter_sel =
      s.calc_filter_config[I2F_LSB +: 2];
   assign voltage1_filter_sel =
      s.calc_filter_config[V1F_LSB +: 2];
   assign voltage2_filter_sel =
      s.calc_filter_config[V2F_LSB +: 2];
   assign iir_bypass =
      s.calc_filter_config[IIR_BIT];

   // phase compensation
   assign coarse_phase1 =
      s.phase_compensation[CP1_LSB +: 2];
   assign coarse_phase2 =
      s.phase_compensation[CP2_LSB +: 2];
   assign fine_phase1 =
      s.phase_compensation[FP1_LSB +: 9];
   assign fine_phase2 =
      s.phase_compensation[FP2_LSB +: 9];

   // serial options
   assign rx_pullup_disable =
      s.serial_control[RXPU_BIT];
   assign rx_checksum_disable =
      s.serial_control[RXCS_BIT];
   assign baud_divisor =
      s.serial_control[BAUD_LSB +: 16];

   // pulse frequency range to the rate logic
   assign pulse_freq_range =
      s.pulse_width_range[RNG_LSB +: 4];

endmodule

// *** meter_cfg_pkg.sv ***
// constants for the metering configuration registers
// assumes a 100 MHz ref_clk and a 6-bit page address
package meter_cfg_pkg;
   // register offsets within the page
   localparam logic [5:0] CALC_FILTER_ADDR = 6'h00;
   localparam logic [5:0] OUT_PIN_ADDR     = 6'h01;
   localparam logic [5:0] PHASE_ADDR       = 6'h05;
   localparam logic [5:0] SERIAL_ADDR      = 6'h07;
   localparam logic [5:0] PULSE_ADDR       = 6'h08;
   // reset values
   localparam logic [23:0] CALC_FILTER_RST = 24'h06_0200;
   localparam logic [23:0] OUT_PIN_RST     = 24'h00_eeee;
   localparam logic [23:0] PHASE_RST       = 24'h00_0000;
   localparam logic [23:0] SERIAL_RST      = 24'h02_004d;
   localparam logic [23:0] PULSE_RST       = 24'h00_0001;
   // writable bits; reserved bits read as zero, except calc/filter bits 17 and 18, which read as one
   localparam logic [23:0] CALC_FILTER_MSK = 24'h40_5fff;
   localparam logic [23:0] CALC_FILTER_ONE = 24'h06_0000;
   localparam logic [23:0] OUT_PIN_MSK     = 24'hff_ffff;
   localparam logic [23:0] PHASE_MSK       = 24'hf3_ffff;
   localparam logic [23:0] SERIAL_MSK      = 24'h06_ffff;
   localparam logic [23:0] PULSE_MSK       = 24'h0f_ffff;
   // output pin register fields
   localparam int EN_LSB  = 20;
   localparam int OD_LSB  = 16;
   localparam int SEL_LSB = 0;
   // calc/filter register fields
   localparam int POS_BIT   = 22;
   localparam int APM_BIT   = 14;
   localparam int ZXLPF_BIT = 12;
   localparam int AVG_BIT   = 11;
   localparam int CSUM_BIT  = 10;
   localparam int ALF_BIT   = 9;
   localparam int I2F_LSB   = 7;
   localparam int V2F_LSB   = 5;
   localparam int I1F_LSB   = 3;
   localparam int V1F_LSB   = 1;
   localparam int IIR_BIT   = 0;
   // phase register fields
   localparam int CP2_LSB = 22;
   localparam int CP1_LSB = 20;
   localparam int FP2_LSB = 9;
   localparam int FP1_LSB = 0;
   // serial and pulse register fields
   localparam int RXPU_BIT = 18;
   localparam int RXCS_BIT = 17;
   localparam int BAUD_LSB  = 0;
   localparam int RNG_LSB   = 16;
   localparam int WIDTH_LSB = 0;
   // pin source codes that release the pin
   localparam logic [3:0] SRC_RSV_A = 4'ha;
   localparam logic [3:0] SRC_RSV_D = 4'hd;
   localparam logic [3:0] SRC_HIZ   = 4'he;
   // pulse timing
   localparam int CLK_HZ        = 100_000_000;
   localparam int PULSE_BASE_US = 250;
   localparam int WIDTH_UNIT_HZ = 64_000;
   localparam int PULSE_BASE_CYCLES = PULSE_BASE_US * (CLK_HZ / 1_000_000);
   localparam int WIDTH_HALF_CYCLES = 2 * CLK_HZ / WIDTH_UNIT_HZ;
   typedef enum logic {PG_IDLE, PG_ACTIVE} pg_state_t;
endpackage

// *** pulse_stretch.sv ***
// one energy pulse generator output stage
// assumes one-cycle triggers on ref_clk
`timescale 1ns/1ps
module pulse_stretch import meter_cfg_pkg::*; #(
   parameter int BASE_CYCLES = PULSE_BASE_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        enable,
   input  wire logic        trigger,
   input  wire logic [15:0] width,
   output logic             pulse
);
   typedef struct packed {
      pg_state_t   st;  // idle or emitting
      logic [28:0] cnt; // elapsed half cycles
   } ps_t;
   ps_t s, next_s;
   logic [28:0] target; // pulse length in half cycles
   // half-cycle units keep the 15.625 us step exact
   assign target = 29'(2 * BASE_CYCLES) + 29'(width * 29'(WIDTH_HALF_CYCLES));
   // next state
   always_comb begin
      next_s = s;
      unique case (s.st)
         PG_IDLE: begin
            if (enable && trigger) begin
               next_s.st  = PG_ACTIVE;
               next_s.cnt = 29'd2;
            end
         end
         PG_ACTIVE: begin
            // disabling cuts a running pulse short
            if (!enable || s.cnt >= target) begin
               next_s.st = PG_IDLE;
            end else begin
               next_s.cnt = s.cnt + 29'd2;
            end
         end
      endcase
   end
   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) s <= '{PG_IDLE, 29'd0};
      else s <= next_s;
   end
   assign pulse = (s.st == PG_ACTIVE);
endmodule

// *** pin_driver.sv ***
// one digital output pin: source mux and drive type
// assumes all sources are on ref_clk
`timescale 1ns/1ps
module pin_driver import meter_cfg_pkg::*; (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  source_sel,
   input  wire logic        open_drain,
   input  wire logic [15:0] sources,
   output logic             pin_out,
   output logic             pin_oe_n
);
   typedef struct packed {
      logic out;  // driven level
      logic oe_n; // low while driving
   } pd_t;
   pd_t s, next_s;
   logic val;
   // pick the source and shape the drive
   always_comb begin
      val = sources[source_sel];
      next_s = '{1'b0, 1'b1};
      if (source_sel == SRC_HIZ || source_sel == SRC_RSV_A ||
          source_sel == SRC_RSV_D) begin
         next_s = '{1'b0, 1'b1};
      end else if (open_drain) begin
         next_s = '{1'b0, val};
      end else begin
         next_s = '{val, 1'b0};
      end
   end
   // output register; released during reset
   always_ff @(posedge ref_clk) begin
      if (rst) s <= '{1'b0, 1'b1};
      else s <= next_s;
   end
   assign pin_out  = s.out;
   assign pin_oe_n = s.oe_n;
endmodule

// *** meter_cfg_checker_sva.sv ***
// concurrent checks on the ports of the metering configuration register block
// assumes it is bound to meter_config_registers on its single ref_clk domain
`timescale 1ns/1ps
module meter_cfg_checker import meter_cfg_pkg::*; (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [5:0]  reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [23:0] reg_rdata,
   input wire logic        line_freq_done,
   input wire logic        epsilon_update,
   input wire logic [3:0]  pin_out,
   input wire logic [3:0]  pin_oe_n,
   input wire logic [3:0]  pulse_gen_enable,
   input wire logic        averaging_source,
   input wire logic        checksum_uses_cycle_count,
   input wire logic        auto_line_freq,
   input wire logic        iir_bypass,
   input wire logic [8:0]  fine_phase1,
   input wire logic [1:0]  coarse_phase2,
   input wire logic [15:0] baud_divisor,
   input wire logic        rx_checksum_disable,
   input wire logic [3:0]  pulse_freq_range
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic mapped;  // address hits one of the five registers
   logic pin_wr;  // write to the output pin register
   assign mapped = reg_addr inside {CALC_FILTER_ADDR, OUT_PIN_ADDR, PHASE_ADDR, SERIAL_ADDR, PULSE_ADDR};
   assign pin_wr = reg_wr && reg_addr == OUT_PIN_ADDR;
   // pin 1 set to release, then left alone long enough for the pin stage to follow
   sequence s_hiz_write;
      pin_wr && reg_wdata[3:0] == SRC_HIZ;
   endsequence
   sequence s_pin_quiet;
      !pin_wr [*3];
   endsequence
   a_unmapped_read_zero: assert property (reg_rd && !mapped |=> reg_rdata == 24'h00_0000)
      else $error("unmapped read not zero");
   a_gen_enable_write: assert property (pin_wr |=> pulse_gen_enable == $past(reg_wdata[23:20]))
      else $error("generator enables not written");
   a_calc_bits_write: assert property (reg_wr && reg_addr == CALC_FILTER_ADDR |=>
      {averaging_source, auto_line_freq, iir_bypass} ==
      {$past(reg_wdata[AVG_BIT]), $past(reg_wdata[ALF_BIT]), $past(reg_wdata[IIR_BIT])})
      else $error("calc bits not written");
   a_cycle_count_follow: assert property (checksum_uses_cycle_count == averaging_source)
      else $error("checksum count source wrong");
   a_serial_field_write: assert property (reg_wr && reg_addr == SERIAL_ADDR |=>
      baud_divisor == $past(reg_wdata[15:0]) && rx_checksum_disable == $past(reg_wdata[RXCS_BIT]))
      else $error("serial fields not written");
   a_baud_hold: assert property (!(reg_wr && reg_addr == SERIAL_ADDR) |=> $stable(baud_divisor))
      else $error("baud divisor changed without write");
   a_range_write: assert property (reg_wr && reg_addr == PULSE_ADDR |=>
      pulse_freq_range == $past(reg_wdata[19:16])) else $error("range not written");
   a_phase_write: assert property (reg_wr && reg_addr == PHASE_ADDR |=>
      fine_phase1 == $past(reg_wdata[8:0]) && coarse_phase2 == $past(reg_wdata[23:22]))
      else $error("phase fields not written");
   a_epsilon_on_done: assert property (line_freq_done && auto_line_freq |=> epsilon_update)
      else $error("gain update missing");
   a_epsilon_quiet: assert property (!(line_freq_done && auto_line_freq) |=> !epsilon_update)
      else $error("gain update without cause");
   a_drive_exclusive: assert property ((pin_out & pin_oe_n) == 4'h0)
      else $error("pin high while released");
   a_hiz_release: assert property (s_hiz_write ##1 s_pin_quiet |-> pin_oe_n[0] && !pin_out[0])
      else $error("pin not released");
endmodule

// *** meter_config_registers_bench.sv ***
// self-checking bench for the metering configuration register block
// assumes the package and the checker file are compiled before this file
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module meter_config_registers_bench import meter_cfg_pkg::*;;
   localparam int     BASE    = 20;                        // shortened base pulse keeps the run short
   localparam int     PLEN    = (2 * BASE + 3125 + 1) / 2; // pulse cycles for width value 1
   localparam longint MCLK_HZ = 4_096_000;                 // assumed meter master clock
   localparam longint BAUD_VAL = 64'd9600 * 64'd524_288 / MCLK_HZ;
   localparam logic [5:0]  ADR [5] = '{CALC_FILTER_ADDR, OUT_PIN_ADDR, PHASE_ADDR, SERIAL_ADDR, PULSE_ADDR};
   localparam logic [23:0] RV  [5] = '{CALC_FILTER_RST, OUT_PIN_RST, PHASE_RST, SERIAL_RST, PULSE_RST};
   localparam logic [23:0] MK  [5] = '{CALC_FILTER_MSK, OUT_PIN_MSK, PHASE_MSK, SERIAL_MSK, PULSE_MSK};
   localparam logic [23:0] ON  [5] = '{CALC_FILTER_ONE, 24'h0, 24'h0, 24'h0, 24'h0};
   logic        ref_clk, rst, reg_wr, reg_rd, avg_power_valid, line_freq_done, epsilon_update;
   logic [5:0]  reg_addr;
   logic [23:0] reg_wdata, reg_rdata, p1_avg_raw, p2_avg_raw, p1_avg, p2_avg;
   logic [3:0]  epg_trigger, pin_out, pin_oe_n, pulse_gen_enable, pulse_freq_range;
   logic [15:0] src, baud_divisor;  // src holds pin source levels indexed by selector code
   int          fail_count, n_checks;
   meter_config_registers #(.BASE_CYCLES(BASE)) meter_config_registers_inst (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .epg_trigger(epg_trigger), .active_sign1(src[4]),
      .active_sign2(src[5]), .active_sign_sum(src[6]), .reactive_sign1(src[7]), .reactive_sign2(src[8]),
      .reactive_sign_sum(src[9]), .voltage_zero_cross(src[11]), .current_zero_cross(src[12]),
      .interrupt_level(src[15]), .avg_power_valid(avg_power_valid), .p1_avg_raw(p1_avg_raw),
      .p2_avg_raw(p2_avg_raw), .p1_avg(p1_avg), .p2_avg(p2_avg), .line_freq_done(line_freq_done),
      .epsilon_update(epsilon_update), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pulse_gen_enable(pulse_gen_enable), .apparent_power_method(), .zero_cross_lowpass(),
      .averaging_source(), .critical_checksum_disable(), .checksum_uses_cycle_count(), .auto_line_freq(),
      .current1_filter_sel(), .current2_filter_sel(), .voltage1_filter_sel(), .voltage2_filter_sel(),
      .iir_bypass(), .coarse_phase1(), .coarse_phase2(), .fine_phase1(), .fine_phase2(),
      .rx_pullup_disable(), .rx_checksum_disable(), .baud_divisor(baud_divisor),
      .pulse_freq_range(pulse_freq_range));
   // one-cycle write strobe; a following access waits one edge so the strobe never doubles up
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data is registered, so it is looked at just after the taking edge
   task automatic rd(input logic [5:0] a, input logic [23:0] ex);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", ex, reg_rdata)
   endtask
   // all four pins share one code; released, open-drain and push-pull outcomes
   task automatic pins(input logic v, input logic od, input logic rel);
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("pin_out", (rel || od) ? 4'h0 : {4{v}}, pin_out)
      `CHK("pin_oe_n", rel ? 4'hf : (od ? {4{v}} : 4'h0), pin_oe_n)
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // cut a hang well after the expected run of about 9900 cycles
   initial begin
      repeat (40000) @(posedge ref_clk);
      fail_count++;
      wrap_up();
   end
   initial begin
      int  cnt;
      logic hi4, rel;
      {rst, reg_wr, reg_rd, avg_power_valid, line_freq_done} = 5'b10000;
      {reg_addr, reg_wdata, p1_avg_raw, p2_avg_raw, epg_trigger, src} = '0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      // reset values, then every writable bit set and cleared
      for (int i = 0; i < 5; i++) begin
         rd(ADR[i], RV[i]);
         wr(ADR[i], 24'hff_ffff);
         rd(ADR[i], MK[i] | ON[i]);
         wr(ADR[i], 24'h00_0000);
         rd(ADR[i], ON[i]);
         wr(ADR[i], RV[i]);
      end
      wr(6'h03, 24'hff_ffff);
      rd(6'h03, 24'h00_0000);
      wr(SERIAL_ADDR, {8'h00, BAUD_VAL[15:0]});
      #1;
      `CHK("baud_divisor", BAUD_VAL[15:0], baud_divisor)
      // one-hot and inverted sources catch a swapped route
      for (int od = 0; od < 2; od++) begin
         for (int c = 0; c < 16; c++) begin
            wr(OUT_PIN_ADDR, {4'h0, {4{od[0]}}, {4{c[3:0]}}});
            rel = (c == 10 || c == 13 || c == 14);
            src <= 16'h0001 << c;
            pins(c > 3, od[0], rel);
            src <= ~(16'h0001 << c);
            pins(1'b0, od[0], rel);
         end
      end
      // width value 1; a second request mid-pulse must not stretch it; gen 4 off on the second pass
      wr(PULSE_ADDR, 24'h00_0001);
      for (int k = 0; k < 2; k++) begin
         wr(OUT_PIN_ADDR, k ? 24'h70_3210 : 24'hf0_3210);
         cnt = 0;
         hi4 = 1'b0;
         for (int j = 0; j < 3 * PLEN; j++) begin
            @(posedge ref_clk);
            epg_trigger <= (j == 0 || j == 50) ? 4'hf : 4'h0;
            #1;
            cnt += pin_out[0];
            hi4 |= pin_out[3];
         end
         `CHK("pulse_len", PLEN, cnt)
         `CHK("gen4_pulse", k == 0, hi4)
      end
      // negative averaged power kept or zeroed
      for (int p = 0; p < 2; p++) begin
         wr(CALC_FILTER_ADDR, CALC_FILTER_RST | (24'(p) << POS_BIT));
         avg_power_valid <= 1'b1;
         p1_avg_raw <= 24'hff_fff0;
         p2_avg_raw <= 24'h00_0123;
         @(posedge ref_clk);
         avg_power_valid <= 1'b0;
         #1;
         `CHK("p1_avg", p ? 24'h00_0000 : 24'hff_fff0, p1_avg)
         `CHK("p2_avg", 24'h00_0123, p2_avg)
      end
      // gain update follows a finished frequency measurement only when enabled
      for (int a = 0; a < 2; a++) begin
         wr(CALC_FILTER_ADDR, CALC_FILTER_RST & ~(24'(a) << ALF_BIT));
         line_freq_done <= 1'b1;
         @(posedge ref_clk);
         line_freq_done <= 1'b0;
         #1;
         `CHK("epsilon_update", a == 0, epsilon_update)
      end
      wrap_up();
   end
endmodule
bind meter_config_registers meter_cfg_checker chk_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .line_freq_done(line_freq_done), .epsilon_update(epsilon_update), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .pulse_gen_enable(pulse_gen_enable), .averaging_source(averaging_source),
   .checksum_uses_cycle_count(checksum_uses_cycle_count), .auto_line_freq(auto_line_freq),
   .iir_bypass(iir_bypass), .fine_phase1(fine_phase1), .coarse_phase2(coarse_phase2),
   .baud_divisor(baud_divisor), .rx_checksum_disable(rx_checksum_disable), .pulse_freq_range(pulse_freq_range));
